// *** verilog/ccsc_pkg.sv ***
`default_nettype none
package ccsc_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 4;
    // Least time the strap pins must settle after reset release.
    localparam int STRAP_SETTLE_NS = 100;
    localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FRAME_PERIOD_US = 33367;
    localparam int FRAME_CYC = FRAME_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int VSYNC_US = 190;
    localparam int VSYNC_CYC = VSYNC_US * 1000 / CLK_PERIOD_NS;

    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam logic [7:0] CTRL_D_OFF = 8'h00;
    localparam logic [7:0] CTRL_E_OFF = 8'h04;
    localparam logic [7:0] CTRL_J_OFF = 8'h08;
    localparam logic [7:0] BRIGHT_OFF = 8'h0C;
    localparam logic [7:0] SATUR_OFF = 8'h10;
    localparam logic [7:0] HUE_OFF = 8'h14;
    localparam logic [7:0] MISC_OFF = 8'h18;
    localparam logic [7:0] STATUS_OFF = 8'h1C;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int WB_AUTO_BIT = 1;
    localparam int MIRROR_BIT = 6;
    localparam int BACKLIGHT_BIT = 4;
    localparam int FLIP_BIT = 0;
    localparam int SATUR_HI = 7;
    localparam int SATUR_LO = 4;
    localparam int HUE_HI = 5;
    localparam int HUE_LO = 0;
    localparam int MISC_ABRIGHT_BIT = 0;
    localparam int MISC_GAMMA_BIT = 1;
    localparam int MISC_SPEED_BIT = 2;
    localparam int MISC_MASTER_BIT = 3;
    localparam int MISC_GAIN_LO = 4;
    localparam int MISC_GAIN_HI = 5;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_SERIAL_BIT = 1;
    localparam int STAT_FIELD_BIT = 2;
    localparam int STAT_STRAP_LO = 4;

    // Strap vector order; the serial enable rides on top.
    localparam int STRAP_ABRIGHT = 0;
    localparam int STRAP_BACKLIGHT = 1;
    localparam int STRAP_FLIP = 2;
    localparam int STRAP_GAMMA = 3;
    localparam int STRAP_MIRROR = 4;
    localparam int STRAP_GAIN = 5;
    localparam int STRAP_SPEED = 6;
    localparam int STRAP_W = 7;
    localparam int SERIAL_EN_N_IDX = 7;

    // ==========================================================
    // Reset values and codes
    // ==========================================================
    localparam logic [7:0] CTRL_D_RST = 8'h02;
    localparam logic [7:0] CTRL_E_RST = 8'h00;
    localparam logic [7:0] CTRL_J_RST = 8'h00;
    localparam logic [7:0] BRIGHT_RST = 8'h80;
    localparam logic [7:0] SATUR_RST = 8'h80;
    localparam logic [7:0] HUE_RST = 8'h00;
    localparam logic [7:0] MISC_RST = 8'h2F;
    localparam logic [7:0] PIN_SYNC_RST = 8'h80;
    localparam logic [1:0] GAIN_MAX_4X = 2'h1;
    localparam logic [1:0] GAIN_MAX_8X = 2'h2;
    localparam logic [1:0] GAIN_MAX_16X = 2'h3;

endpackage
`default_nettype wire

// *** verilog/ccsc_frame_timing.sv ***
`timescale 1ns/10ps
`default_nettype none
module ccsc_frame_timing
    import ccsc_pkg::*;
#(
    parameter int FRAME_CYCLES = FRAME_CYC,
    parameter int VSYNC_CYCLES = VSYNC_CYC
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Mode and sync pin
    input wire logic master_i,
    input wire logic sync_pin_i,
    // Frame timing
    output logic frame_start_o,
    output logic field_flag_o,
    output logic vsync_o,
    output logic active_o
);

    // ==========================================================
    // Sync input crossing
    // ==========================================================
    logic sync_meta_reg;
    logic sync_q_reg;
    logic sync_d_reg;
    logic sync_rise;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync_meta_reg <= 1'b0;
            sync_q_reg <= 1'b0;
            sync_d_reg <= 1'b0;
        end
        else
        begin
            sync_meta_reg <= sync_pin_i;
            sync_q_reg <= sync_meta_reg;
            sync_d_reg <= sync_q_reg;
        end
    end

    assign sync_rise = sync_q_reg && !sync_d_reg;

    // ==========================================================
    // Frame counter
    // ==========================================================
    logic [23:0] cnt_reg;
    logic [23:0] cnt_next;
    logic restart;

    assign restart = (!master_i && sync_rise) || (cnt_reg == 24'(FRAME_CYCLES - 1));
    assign cnt_next = restart ? 24'h00_0000 : cnt_reg + 24'h00_0001;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_reg <= 24'h00_0000;
            frame_start_o <= 1'b0;
            field_flag_o <= 1'b0;
            vsync_o <= 1'b0;
            active_o <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            frame_start_o <= restart;
            // field flag rises at frame start
            field_flag_o <= cnt_next < 24'(FRAME_CYCLES / 2);
            vsync_o <= cnt_next < 24'(VSYNC_CYCLES);
            active_o <= cnt_next >= 24'(VSYNC_CYCLES);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sync_out_a:
        assert property (master_i && frame_start_o |-> field_flag_o && !$past(field_flag_o))
        else $error("master frame start without field flag rise");
    slave_align_a:
        assert property (!master_i && sync_rise |=> frame_start_o && cnt_reg == 24'h00_0000)
        else $error("slave did not realign to sync input");

endmodule
`default_nettype wire

// *** verilog/ccsc_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module ccsc_top
    import ccsc_pkg::*;
#(
    parameter int FRAME_CYCLES = FRAME_CYC,
    parameter int VSYNC_CYCLES = VSYNC_CYC
)
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Control and strap inputs
    input wire logic SERIAL_IF_ENABLE_N_I,
    input wire logic FRAME_SYNC_IN_I,
    input wire logic AUTO_BRIGHTNESS_STRAP_I,
    input wire logic BACKLIGHT_STRAP_I,
    input wire logic GAMMA_STRAP_I,
    input wire logic EXPOSURE_SPEED_STRAP_I,
    // Strap pins that become outputs
    input wire logic VALID_PIXEL_OUT_FLIP_STRAP_I,
    output logic VALID_PIXEL_OUT_FLIP_STRAP_O,
    output logic VALID_PIXEL_OUT_FLIP_STRAP_OE_O,
    input wire logic MIRROR_STRAP_I,
    output logic MIRROR_STRAP_O,
    output logic MIRROR_STRAP_OE_O,
    input wire logic GAIN_RANGE_STRAP_I,
    output logic FIELD_FLAG_SYNC_OUT_O,
    output logic FIELD_FLAG_SYNC_OUT_OE_O,
    // Effective settings
    output logic AUTO_WHITE_BALANCE_O,
    output logic MIRROR_O,
    output logic VERTICAL_FLIP_O,
    output logic BACKLIGHT_O,
    output logic AUTO_BRIGHTNESS_O,
    output logic GAMMA_O,
    output logic FAST_EXPOSURE_O,
    output logic [1:0] GAIN_MAX_O,
    output logic [7:0] BRIGHTNESS_LEVEL_O,
    output logic [3:0] SATURATION_LEVEL_O,
    output logic [5:0] HUE_O
);

    typedef enum logic {ST_SETTLE, ST_LATCHED} ccsc_strap_state_t;

    // ==========================================================
    // Reset and pin synchronisers
    // ==========================================================
    logic rst_meta_reg;
    logic rst_n;
    logic [STRAP_W:0] pin_meta_reg;
    logic [STRAP_W:0] pin_sync_reg;

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_reg <= PIN_SYNC_RST;
            pin_sync_reg <= PIN_SYNC_RST;
        end
        else
        begin
            pin_meta_reg <= {SERIAL_IF_ENABLE_N_I, EXPOSURE_SPEED_STRAP_I, GAIN_RANGE_STRAP_I,
                             MIRROR_STRAP_I, GAMMA_STRAP_I, VALID_PIXEL_OUT_FLIP_STRAP_I,
                             BACKLIGHT_STRAP_I, AUTO_BRIGHTNESS_STRAP_I};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ==========================================================
    // Strap capture
    // ==========================================================
    ccsc_strap_state_t state_reg;
    logic [7:0] settle_cnt_reg;
    logic [STRAP_W-1:0] strap_reg;
    logic settle_last;
    logic strap_done;
    logic serial_on;

    assign settle_last = settle_cnt_reg == 8'(STRAP_SETTLE_CYC - 1);
    assign strap_done = state_reg == ST_LATCHED;
    assign serial_on = strap_done && !pin_sync_reg[SERIAL_EN_N_IDX];

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_SETTLE;
            settle_cnt_reg <= 8'h00;
        end
        else
        begin
            unique case (state_reg)
                ST_SETTLE:
                begin
                    settle_cnt_reg <= settle_cnt_reg + 8'h01;
                    if (settle_last)
                    begin
                        state_reg <= ST_LATCHED;
                    end
                end
                ST_LATCHED:
                begin
                    settle_cnt_reg <= settle_cnt_reg;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_reg <= '0;
        end
        else if (state_reg == ST_SETTLE && settle_last)
        begin
            strap_reg <= pin_sync_reg[STRAP_W-1:0];
        end
    end

    // ==========================================================
    // Register file
    // ==========================================================
    logic [7:0] common_control_d_reg;
    logic [7:0] common_control_e_reg;
    logic [7:0] common_control_j_reg;
    logic [7:0] bright_reg;
    logic [7:0] satur_reg;
    logic [7:0] hue_reg;
    logic [7:0] misc_reg;
    logic wr_en;
    logic setup;
    logic [31:0] rd_word;
    logic rd_hit;

    assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
    assign setup = PSEL_I && !PENABLE_I;

    // write side of the control registers
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            common_control_d_reg <= CTRL_D_RST;
            common_control_e_reg <= CTRL_E_RST;
            common_control_j_reg <= CTRL_J_RST;
            bright_reg <= BRIGHT_RST;
            satur_reg <= SATUR_RST;
            hue_reg <= HUE_RST;
            misc_reg <= MISC_RST;
        end
        else if (wr_en)
        begin
            case (PADDR_I)
                CTRL_D_OFF: common_control_d_reg <= PWDATA_I[7:0];
                CTRL_E_OFF: common_control_e_reg <= PWDATA_I[7:0];
                CTRL_J_OFF: common_control_j_reg <= PWDATA_I[7:0];
                BRIGHT_OFF: bright_reg <= PWDATA_I[7:0];
                SATUR_OFF: satur_reg <= PWDATA_I[7:0];
                HUE_OFF: hue_reg <= PWDATA_I[7:0];
                MISC_OFF: misc_reg <= PWDATA_I[7:0];
                default: ;
            endcase
        end
    end

    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (PADDR_I)
            CTRL_D_OFF: rd_word[7:0] = common_control_d_reg;
            CTRL_E_OFF: rd_word[7:0] = common_control_e_reg;
            CTRL_J_OFF: rd_word[7:0] = common_control_j_reg;
            BRIGHT_OFF: rd_word[7:0] = bright_reg;
            SATUR_OFF: rd_word[7:0] = satur_reg;
            HUE_OFF: rd_word[7:0] = hue_reg;
            MISC_OFF: rd_word[7:0] = misc_reg;
            STATUS_OFF:
            begin
                rd_word[STAT_DONE_BIT] = strap_done;
                rd_word[STAT_SERIAL_BIT] = serial_on;
                rd_word[STAT_FIELD_BIT] = FIELD_FLAG_SYNC_OUT_O;
                rd_word[STAT_STRAP_LO +: STRAP_W] = strap_reg;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // Read data is settled in the setup cycle so the access needs no wait state.
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            PRDATA_O <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end
        else if (setup)
        begin
            PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rd_word;
            PSLVERR_O <= !rd_hit || (PWRITE_I && PADDR_I == STATUS_OFF);
        end
    end

    assign PREADY_O = 1'b1;

    // ==========================================================
    // Frame timing and shared pins
    // ==========================================================
    logic frame_start;
    logic field_flag;
    logic vsync;
    logic active;

    ccsc_frame_timing #(
        .FRAME_CYCLES(FRAME_CYCLES),
        .VSYNC_CYCLES(VSYNC_CYCLES)
    ) u_timing (
        .clk_i(CLK_I),
        .rst_n_i(rst_n),
        .master_i(misc_reg[MISC_MASTER_BIT]),
        .sync_pin_i(FRAME_SYNC_IN_I),
        .frame_start_o(frame_start),
        .field_flag_o(field_flag),
        .vsync_o(vsync),
        .active_o(active)
    );

    // Shared pins stay inputs until the straps are captured.
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            VALID_PIXEL_OUT_FLIP_STRAP_O <= 1'b0;
            MIRROR_STRAP_O <= 1'b0;
            FIELD_FLAG_SYNC_OUT_O <= 1'b0;
            VALID_PIXEL_OUT_FLIP_STRAP_OE_O <= 1'b0;
            MIRROR_STRAP_OE_O <= 1'b0;
            FIELD_FLAG_SYNC_OUT_OE_O <= 1'b0;
        end
        else
        begin
            VALID_PIXEL_OUT_FLIP_STRAP_O <= active;
            MIRROR_STRAP_O <= vsync;
            // field flag carries the frame sync
            FIELD_FLAG_SYNC_OUT_O <= field_flag;
            VALID_PIXEL_OUT_FLIP_STRAP_OE_O <= strap_done;
            MIRROR_STRAP_OE_O <= strap_done;
            FIELD_FLAG_SYNC_OUT_OE_O <= strap_done;
        end
    end

    // ==========================================================
    // Effective settings
    // ==========================================================
    // A field only replaces the strap at a frame start, but the strap returns at once when serial goes off.
    function automatic logic pick_bit(input logic ser, input logic fs, input logic cur,
                                      input logic fld, input logic strap);
        if (!ser)
        begin
            return strap;
        end
        return fs ? fld : cur;
    endfunction

    function automatic logic [1:0] gain_decode(input logic [1:0] code);
        return (code == 2'h0) ? GAIN_MAX_8X : code;
    endfunction

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            MIRROR_O <= 1'b0;
            VERTICAL_FLIP_O <= 1'b0;
            BACKLIGHT_O <= 1'b0;
            AUTO_BRIGHTNESS_O <= 1'b0;
            GAMMA_O <= 1'b0;
            FAST_EXPOSURE_O <= 1'b0;
            GAIN_MAX_O <= GAIN_MAX_8X;
        end
        else
        begin
            // fields replace straps when serial on
            MIRROR_O <= pick_bit(serial_on, frame_start, MIRROR_O,
                                 common_control_e_reg[MIRROR_BIT], strap_reg[STRAP_MIRROR]);
            VERTICAL_FLIP_O <= pick_bit(serial_on, frame_start, VERTICAL_FLIP_O,
                                        common_control_j_reg[FLIP_BIT], strap_reg[STRAP_FLIP]);
            BACKLIGHT_O <= pick_bit(serial_on, frame_start, BACKLIGHT_O,
                                    common_control_e_reg[BACKLIGHT_BIT], strap_reg[STRAP_BACKLIGHT]);
            AUTO_BRIGHTNESS_O <= pick_bit(serial_on, frame_start, AUTO_BRIGHTNESS_O,
                                          misc_reg[MISC_ABRIGHT_BIT], strap_reg[STRAP_ABRIGHT]);
            GAMMA_O <= pick_bit(serial_on, frame_start, GAMMA_O,
                                misc_reg[MISC_GAMMA_BIT], strap_reg[STRAP_GAMMA]);
            FAST_EXPOSURE_O <= pick_bit(serial_on, frame_start, FAST_EXPOSURE_O,
                                        !misc_reg[MISC_SPEED_BIT], !strap_reg[STRAP_SPEED]);
            // field selects 4x, 8x or 16x
            if (!serial_on)
            begin
                GAIN_MAX_O <= strap_reg[STRAP_GAIN] ? GAIN_MAX_8X : GAIN_MAX_4X;
            end
            else if (frame_start)
            begin
                GAIN_MAX_O <= gain_decode(misc_reg[MISC_GAIN_HI:MISC_GAIN_LO]);
            end
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            AUTO_WHITE_BALANCE_O <= 1'b0;
            BRIGHTNESS_LEVEL_O <= 8'h00;
            SATURATION_LEVEL_O <= 4'h0;
            HUE_O <= 6'h00;
        end
        else
        begin
            // white balance from control-d bit 1
            AUTO_WHITE_BALANCE_O <= common_control_d_reg[WB_AUTO_BIT];
            BRIGHTNESS_LEVEL_O <= bright_reg;
            SATURATION_LEVEL_O <= satur_reg[SATUR_HI:SATUR_LO];
            HUE_O <= hue_reg[HUE_HI:HUE_LO];
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!rst_n);

    sequence wb_write_s;
        wr_en && PADDR_I == CTRL_D_OFF;
    endsequence

    white_bal_a:
        assert property (wb_write_s ##2 1 |-> AUTO_WHITE_BALANCE_O == $past(PWDATA_I[WB_AUTO_BIT], 2))
        else $error("white balance does not follow its bit");
    mirror_frame_a:
        assert property (serial_on && frame_start |=> MIRROR_O == $past(common_control_e_reg[MIRROR_BIT]))
        else $error("mirror not loaded at frame start");
    flip_frame_a:
        assert property (serial_on && frame_start |=> VERTICAL_FLIP_O == $past(common_control_j_reg[FLIP_BIT]))
        else $error("flip not loaded at frame start");
    strap_hold_a:
        assert property (strap_done |=> $stable(strap_reg) && strap_done)
        else $error("latched straps changed");
    strap_default_a:
        assert property (!serial_on |=> MIRROR_O == $past(strap_reg[STRAP_MIRROR]))
        else $error("strap not used while serial disabled");
    frame_hold_a:
        assert property (serial_on && !frame_start |=> $stable(MIRROR_O) && $stable(GAIN_MAX_O))
        else $error("override applied mid frame");
    gain_strap_a:
        assert property (!serial_on && strap_done |=>
                         GAIN_MAX_O == ($past(strap_reg[STRAP_GAIN]) ? GAIN_MAX_8X : GAIN_MAX_4X))
        else $error("gain strap decode wrong");
    unmapped_a:
        assert property (setup && !rd_hit |=> PSLVERR_O)
        else $error("unmapped access not flagged");
    bright_a:
        assert property (1'b1 |=> BRIGHTNESS_LEVEL_O == $past(bright_reg))
        else $error("brightness level wrong");

endmodule
`default_nettype wire

// *** dv/ccsc_sync_master.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Far-end master camera on the frame sync pin
// ==========================================================
module ccsc_sync_master
(
    // Request from the bench
    input wire logic go_i,
    // Sync pin
    output logic sync_o
);
    logic lclk;
    // The link clock has a fixed phase, so sync edges always land 1 ns before a core rising edge.
    initial
    begin
        lclk = 1'b0;
        #13;
        forever #32 lclk = ~lclk;
    end
    always @(posedge lclk)
        sync_o <= go_i;
endmodule
`default_nettype wire

// *** dv/test_ccsc_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module test_ccsc_top
    import ccsc_pkg::*;
;
    logic CLK_I = 1'b0, RST_N_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O, go;
    logic [7:0] PADDR_I, BRIGHTNESS_LEVEL_O;
    logic [31:0] PWDATA_I, PRDATA_O;
    logic SERIAL_IF_ENABLE_N_I, AUTO_BRIGHTNESS_STRAP_I, BACKLIGHT_STRAP_I, GAMMA_STRAP_I, EXPOSURE_SPEED_STRAP_I;
    logic VALID_PIXEL_OUT_FLIP_STRAP_O, VALID_PIXEL_OUT_FLIP_STRAP_OE_O, MIRROR_STRAP_O, MIRROR_STRAP_OE_O;
    logic FIELD_FLAG_SYNC_OUT_O, FIELD_FLAG_SYNC_OUT_OE_O, AUTO_WHITE_BALANCE_O, MIRROR_O, VERTICAL_FLIP_O;
    logic BACKLIGHT_O, AUTO_BRIGHTNESS_O, GAMMA_O, FAST_EXPOSURE_O, vf_drv, mi_drv, gn_drv;
    logic [1:0] GAIN_MAX_O;
    logic [3:0] SATURATION_LEVEL_O;
    logic [5:0] HUE_O;
    wire logic FRAME_SYNC_IN_I, VALID_PIXEL_OUT_FLIP_STRAP_I, MIRROR_STRAP_I, GAIN_RANGE_STRAP_I;
    logic [7:0] rst_v [7] = '{CTRL_D_RST, CTRL_E_RST, CTRL_J_RST, BRIGHT_RST, SATUR_RST, HUE_RST, MISC_RST};
    int n_mismatch = 0, cmp_count = 0;
    // Strap resistors are weak: once the pin turns output, the device wins.
    assign VALID_PIXEL_OUT_FLIP_STRAP_I = VALID_PIXEL_OUT_FLIP_STRAP_OE_O ? VALID_PIXEL_OUT_FLIP_STRAP_O : vf_drv;
    assign MIRROR_STRAP_I = MIRROR_STRAP_OE_O ? MIRROR_STRAP_O : mi_drv;
    assign GAIN_RANGE_STRAP_I = FIELD_FLAG_SYNC_OUT_OE_O ? FIELD_FLAG_SYNC_OUT_O : gn_drv;
    ccsc_top #(.FRAME_CYCLES(200), .VSYNC_CYCLES(20)) dut_u (.*);
    ccsc_sync_master sync_u (.go_i(go), .sync_o(FRAME_SYNC_IN_I));
    always #2 CLK_I = ~CLK_I;
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_I);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic x);
        PSEL_I <= 1'b1;
        PWRITE_I <= w;
        PADDR_I <= a;
        PWDATA_I <= d;
        @(posedge CLK_I);
        PENABLE_I <= 1'b1;
        do @(posedge CLK_I); while (PREADY_O !== 1'b1);
        r = PRDATA_O;
        x = PSLVERR_O;
        PSEL_I <= 1'b0;
        PENABLE_I <= 1'b0;
        @(posedge CLK_I);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
        logic [31:0] r;
        logic x;
        apb(1'b0, a, 32'h0, r, x);
        `CHK({x, r}, {ee, e})
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        logic [31:0] r;
        logic x;
        apb(1'b1, a, d, r, x);
        `CHK(x, ee)
    endtask
    // Order: auto brightness, backlight, flip, gamma, mirror, fast, gain max.
    task automatic chk_cfg(input logic [7:0] e);
        `CHK({AUTO_BRIGHTNESS_O, BACKLIGHT_O, VERTICAL_FLIP_O, GAMMA_O, MIRROR_O, FAST_EXPOSURE_O, GAIN_MAX_O}, e)
    endtask
    task automatic wait_rise(input int lim);
        logic p;
        p = FIELD_FLAG_SYNC_OUT_O;
        repeat (lim)
        begin
            @(posedge CLK_I);
            if (p === 1'b0 && FIELD_FLAG_SYNC_OUT_O === 1'b1)
                return;
            p = FIELD_FLAG_SYNC_OUT_O;
        end
        `CHK(1'b0, 1'b1)
    endtask
    task automatic end_sim();
        $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_straps();
        chk_cfg(8'hE5);
        {AUTO_BRIGHTNESS_STRAP_I, BACKLIGHT_STRAP_I, GAMMA_STRAP_I, EXPOSURE_SPEED_STRAP_I} <= 4'h3;
        {vf_drv, mi_drv, gn_drv} <= 3'h3;
        tick(5);
        chk_cfg(8'hE5);
    endtask
    task automatic t_regs();
        for (int i = 0; i < 7; i++)
            rd(8'(i * 4), {24'h0, rst_v[i]}, 1'b0);
        rd(8'h20, 32'h0, 1'b1);
        wr(STATUS_OFF, 32'h0, 1'b1);
        wr(CTRL_D_OFF, 32'h0, 1'b0);
        wr(BRIGHT_OFF, 32'h0000_00A5, 1'b0);
        wr(SATUR_OFF, 32'h0000_0070, 1'b0);
        wr(HUE_OFF, 32'h0000_00FF, 1'b0);
        tick(1);
        `CHK({AUTO_WHITE_BALANCE_O, HUE_O}, {1'b0, 6'h3F})
        `CHK({BRIGHTNESS_LEVEL_O, SATURATION_LEVEL_O}, {8'hA5, 4'h7})
        rd(BRIGHT_OFF, 32'h0000_00A5, 1'b0);
    endtask
    task automatic t_override();
        wait_rise(250);
        // Just after the flag rises the sync pin is high and the active-picture pin low.
        `CHK({FIELD_FLAG_SYNC_OUT_OE_O, MIRROR_STRAP_OE_O, VALID_PIXEL_OUT_FLIP_STRAP_OE_O, MIRROR_STRAP_O, VALID_PIXEL_OUT_FLIP_STRAP_O}, 5'h1E)
        wr(CTRL_E_OFF, 32'h0000_0040, 1'b0);
        wr(CTRL_J_OFF, 32'h0, 1'b0);
        wr(MISC_OFF, 32'h0000_003E, 1'b0);
        SERIAL_IF_ENABLE_N_I <= 1'b0;
        tick(3);
        chk_cfg(8'hE5);
        wait_rise(250);
        tick(2);
        chk_cfg(8'h1B);
    endtask
    task automatic t_slave();
        wr(MISC_OFF, 32'h0000_0006, 1'b0);
        wait_rise(250);
        tick(120);
        go <= 1'b1;
        wait_rise(40);
        go <= 1'b0;
        tick(2);
        chk_cfg(8'h1A);
        SERIAL_IF_ENABLE_N_I <= 1'b1;
        tick(4);
        chk_cfg(8'hE5);
    endtask
    // A second reset must latch the straps as they now stand.
    task automatic t_rerst();
        RST_N_I <= 1'b0;
        tick(3);
        RST_N_I <= 1'b1;
        tick(40);
        chk_cfg(8'h1A);
        rd(MISC_OFF, {24'h0, MISC_RST}, 1'b0);
    endtask
    initial
    begin
        {RST_N_I, PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I, go} = '0;
        SERIAL_IF_ENABLE_N_I = 1'b1;
        {AUTO_BRIGHTNESS_STRAP_I, BACKLIGHT_STRAP_I, GAMMA_STRAP_I, EXPOSURE_SPEED_STRAP_I} = 4'hC;
        {vf_drv, mi_drv, gn_drv} = 3'h4;
        tick(3);
        RST_N_I <= 1'b1;
        for (int i = 0; i < 60 && VALID_PIXEL_OUT_FLIP_STRAP_OE_O !== 1'b1; i++)
            @(posedge CLK_I);
        tick(2);
        t_straps();
        t_regs();
        t_override();
        t_slave();
        t_rerst();
        end_sim();
    end
    initial
    begin
        tick(20000);
        n_mismatch++;
        end_sim();
    end
endmodule
`default_nettype wire
